// >>> rtl/usfl_engine.sv
// Bit-level serial engine: 8 data bits, optional even parity, one stop.
// Assumes rx_pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`include "usfl_regs.svh"
module usfl_engine
  import usfl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rx_pin,
  usfl_link_if.eng  lk
);

  // All engine state in one record.
  typedef struct packed {
    logic        s1, s2, s3;   // Receive synchroniser and history.
    usfl_rx_st_t rx_st;        // Receive state.
    logic [15:0] rcnt;         // Receive bit timer.
    logic [2:0]  rbit;         // Receive bit index.
    logic [7:0]  rsh;          // Receive shift register.
    logic        noise;        // Noise seen in this frame.
    logic        perr;         // Parity error of this frame.
    logic        valid;        // Word complete pulse.
    logic [7:0]  rdata;        // Last complete word.
    logic        nf_o, fe_o, pe_o; // Errors of the last word.
    usfl_tx_st_t tx_st;        // Transmit state.
    logic [15:0] tcnt;         // Transmit bit timer.
    logic [2:0]  tbit;         // Transmit bit index.
    logic [7:0]  tsh;          // Transmit shift register.
    logic        tpar;         // Parity bit of the word in flight.
    logic        line;         // Transmit line level.
  } usfl_eng_t;

  localparam logic [15:0] FULL = 16'(`USFL_BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(`USFL_BIT_CYCLES / 2);

  usfl_eng_t q;   // Registered state.
  usfl_eng_t n;   // Next state.
  logic      rt;  // Receive timer expired.
  logic      tt;  // Transmit timer expired.

  // Next-state logic of both directions.
  always_comb begin
    n = q;
    n.valid = 1'b0;
    n.s1 = rx_pin;
    n.s2 = q.s1;
    n.s3 = q.s2;
    rt = (q.rcnt == 16'h0000);
    tt = (q.tcnt == 16'h0000);
    if (!rt) n.rcnt = q.rcnt - 16'h0001;
    if (!tt) n.tcnt = q.tcnt - 16'h0001;
    unique case (q.rx_st)
      RX_IDLE: if (!q.s2) begin
        n.rx_st = RX_START;
        n.rcnt  = HALF;
        n.noise = 1'b0;
        n.perr  = 1'b0;
      end
      RX_START: if (rt) begin
        // A start bit gone by mid-bit was a glitch.
        n.rx_st = q.s2 ? RX_IDLE : RX_DATA;
        n.rcnt  = FULL;
        n.rbit  = 3'h0;
      end
      RX_DATA: if (rt) begin
        n.rsh   = {q.s2, q.rsh[7:1]};
        n.noise = q.noise | (q.s2 != q.s3);
        n.rbit  = q.rbit + 3'h1;
        n.rcnt  = FULL;
        if (q.rbit == 3'h7) n.rx_st = lk.parity_en ? RX_PAR : RX_STOP;
      end
      RX_PAR: if (rt) begin
        n.perr  = q.s2 ^ (^q.rsh);
        n.noise = q.noise | (q.s2 != q.s3);
        n.rx_st = RX_STOP;
        n.rcnt  = FULL;
      end
      RX_STOP: if (rt) begin
        n.valid = 1'b1;
        n.rdata = q.rsh;
        n.fe_o  = ~q.s2;
        n.nf_o  = q.noise | (q.s2 != q.s3);
        n.pe_o  = q.perr;
        n.rx_st = RX_END;
        n.rcnt  = HALF;
      end
      RX_END: if (rt) n.rx_st = RX_IDLE;
      default: n.rx_st = RX_IDLE;
    endcase
    unique case (q.tx_st)
      TX_IDLE: begin
        n.line = ~lk.tx_break;
        if (lk.tx_load) begin
          n.tsh   = lk.tx_data;
          n.tpar  = ^lk.tx_data;
          n.tx_st = TX_START;
          n.line  = 1'b0;
          n.tcnt  = FULL;
        end
      end
      TX_START: if (tt) begin
        n.tx_st = TX_DATA;
        n.line  = q.tsh[0];
        n.tsh   = {1'b0, q.tsh[7:1]};
        n.tbit  = 3'h0;
        n.tcnt  = FULL;
      end
      TX_DATA: if (tt) begin
        n.tcnt = FULL;
        n.tbit = q.tbit + 3'h1;
        n.line = q.tsh[0];
        n.tsh  = {1'b0, q.tsh[7:1]};
        if (q.tbit == 3'h7) begin
          n.tx_st = lk.parity_en ? TX_PAR : TX_STOP;
          n.line  = lk.parity_en ? q.tpar : 1'b1;
        end
      end
      TX_PAR: if (tt) begin
        n.tx_st = TX_STOP;
        n.line  = 1'b1;
        n.tcnt  = FULL;
      end
      TX_STOP: if (tt) begin
        n.tx_st = TX_IDLE;
        n.line  = 1'b1;
      end
      default: n.tx_st = TX_IDLE;
    endcase
    // Disabling ends any frame at once; the synchroniser keeps running.
    if (!lk.enable) begin
      n.rx_st = RX_IDLE;
      n.tx_st = TX_IDLE;
      n.valid = 1'b0;
      n.line  = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, rx_st: RX_IDLE,
             tx_st: TX_IDLE, line: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign lk.tx_busy  = (q.tx_st != TX_IDLE);
  assign lk.tx_line  = q.line;
  assign lk.rx_busy  = (q.rx_st != RX_IDLE);
  assign lk.rx_valid = q.valid;
  assign lk.rx_data  = q.rdata;
  assign lk.rx_noise = q.nf_o;
  assign lk.rx_ferr  = q.fe_o;
  assign lk.rx_perr  = q.pe_o;

endmodule

// >>> rtl/usfl_link_if.sv
// Bundle between the flag logic and the serial engine.
// Assumes both ends run on the same clock; no crossing inside.
`timescale 1ns/1ps
interface usfl_link_if;
  logic       enable;    // Port enabled; engine idles when low.
  logic       parity_en; // Even parity bit framed after the data.
  logic       tx_break;  // Drive a break while the sender is idle.
  logic       tx_load;   // One-cycle pulse: take tx_data.
  logic [7:0] tx_data;   // Word for the transmit shift register.
  logic       tx_busy;   // A word is being shifted out.
  logic       tx_line;   // Serial line level from the engine.
  logic       rx_busy;   // Start bit seen, stop bit not yet over.
  logic       rx_valid;  // One-cycle pulse: a word is complete.
  logic [7:0] rx_data;   // Received word.
  logic       rx_noise;  // Samples of the word disagreed.
  logic       rx_ferr;   // Stop bit was low.
  logic       rx_perr;   // Parity did not match.

  modport ctl (output enable, parity_en, tx_break, tx_load, tx_data,
               input tx_busy, tx_line, rx_busy, rx_valid, rx_data,
               rx_noise, rx_ferr, rx_perr);
  modport eng (input enable, parity_en, tx_break, tx_load, tx_data,
               output tx_busy, tx_line, rx_busy, rx_valid, rx_data,
               rx_noise, rx_ferr, rx_perr);
endinterface

// >>> rtl/usfl_pkg.sv
// Types shared by the status flag block and its serial engine.
// Assumes the constants of usfl_regs.svh are included where needed.
package usfl_pkg;

  // Receive engine states.
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_PAR   = 3'h3,
    RX_STOP  = 3'h4,
    RX_END   = 3'h5
  } usfl_rx_st_t;

  // Transmit engine states.
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h2,
    TX_PAR   = 3'h3,
    TX_STOP  = 3'h4
  } usfl_tx_st_t;

endpackage

// >>> rtl/usfl_regs.svh
// Register offsets, field positions, reset values and timing counts of
// the serial port status flag block.
// Assumes a 40 MHz system clock and byte addresses on an APB bus.
`ifndef USFL_REGS_SVH
`define USFL_REGS_SVH

// Byte offsets of the registers on the APB bus.
`define USFL_OFF_STATUS   8'h00
`define USFL_OFF_DATA     8'h04
`define USFL_OFF_CTRL     8'h08
`define USFL_OFF_IRQ_STAT 8'h0c
`define USFL_OFF_IRQ_MASK 8'h10

// Bit positions of the status register.
`define USFL_ST_PERR  7
`define USFL_ST_NF    6
`define USFL_ST_FERR  5
`define USFL_ST_OERR  4
`define USFL_ST_RIDLE 3
`define USFL_ST_RXIF  2
`define USFL_ST_TIDLE 1
`define USFL_ST_TXIF  0

// Bit positions of the control register.
`define USFL_CT_EN   0
`define USFL_CT_TXEN 1
`define USFL_CT_RIE  2
`define USFL_CT_PAR  3
`define USFL_CT_BRK  4

// Bit positions of the interrupt status and mask registers.
`define USFL_IRQ_RX    0
`define USFL_IRQ_OVR   1
`define USFL_IRQ_TXE   2
`define USFL_IRQ_TIDLE 3
`define USFL_IRQ_ERR   4

// Reset values.
`define USFL_STATUS_RST 8'h0b
`define USFL_CTRL_RST   5'h00
`define USFL_IRQ_RST    5'h00

// Bit timing: clock rate in Hz, line rate in bit/s, cycles per bit.
`define USFL_CLK_HZ     40000000
`define USFL_BAUD       115200
`define USFL_BIT_CYCLES (`USFL_CLK_HZ / `USFL_BAUD)

`endif

// >>> rtl/usfl_top.sv
// Status flag logic of the serial port, with its APB register file.
// Assumes an APB master on clk and a remote serial partner on the pins.
//
// Notes on behaviour
// - Overrun set when full buffer gets word.
// - Overrun blocks further moves into data register.
// - Status read then data access clears overrun.
// - Receiver idle low from start to stop.
// - Word moved sets data ready, maybe interrupt.
// - Error flags set with data ready flag.
// - Data ready cleared by status then data read.
// - Transmitter idle set when empty and not shifting.
// - Transmit line high while transmitter idle.
// - Status read then data write clears idle.
// - No idle while word or break queued.
// - Buffer empty set when shifter takes word.
// - Status read then data write clears empty.
// - Setting transmit enable sets buffer empty.
// - Port disable clears errors, sets idle flags.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "usfl_regs.svh"
module usfl_top
  import usfl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        rx_pin,
  output      logic        tx_pin,
  output      logic        irq
);

  // All block state in one record.
  typedef struct packed {
    logic [4:0]  ctrl;     // Control register.
    logic [7:0]  st;       // Status flags.
    logic [7:0]  snap;     // Flags seen by the last status read.
    logic        snap_v;   // A status read awaits its data access.
    logic [7:0]  rxdat;    // Receive data register.
    logic [7:0]  txdat;    // Transmit data register.
    logic        tx_full;  // Transmit data register holds a word.
    logic        load;     // Pulse handing txdat to the shifter.
    logic [4:0]  irq_st;   // Sticky interrupt events.
    logic [4:0]  irq_mask; // Interrupt mask, one enables.
    logic [31:0] rdata;    // Read data for the access phase.
    logic        txp;      // Registered transmit pin.
  } usfl_top_t;

  usfl_top_t   q;       // Registered state.
  usfl_top_t   n;       // Next state.
  logic        acc;     // Access phase of a transfer.
  logic        wr;      // Write completes this edge.
  logic        rd;      // Read completes this edge.
  logic        setup;   // Setup phase of a read.
  logic        data_ac; // Any completed access to the data register.
  logic [4:0]  ev;      // Interrupt events of this cycle.

  usfl_link_if lk ();   // Bundle to the serial engine.

  // Address match against one register offset.
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // True when the address names any register of the block.
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `USFL_OFF_STATUS) | hit(a, `USFL_OFF_DATA) |
             hit(a, `USFL_OFF_CTRL) | hit(a, `USFL_OFF_IRQ_STAT) |
             hit(a, `USFL_OFF_IRQ_MASK);
  endfunction

  // The bit engine; it owns bit timing, framing and error detection.
  usfl_engine u_engine (
    .clk    (clk),
    .rst    (rst),
    .rx_pin (rx_pin),
    .lk     (lk)
  );

  // Bus phase decode. The slave never stalls, so every access phase
  // completes at its first edge.
  always_comb begin
    acc     = psel & penable;
    wr      = acc & pwrite;
    rd      = acc & ~pwrite;
    setup   = psel & ~penable & ~pwrite;
    data_ac = acc & hit(paddr, `USFL_OFF_DATA);
  end

  // Next-state logic. Clears are applied first and sets after them, so
  // an event in the same cycle as its clear is kept.
  always_comb begin
    n = q;
    n.load = 1'b0;
    ev = 5'h00;

    // Read data is captured in the setup cycle so that it comes from a
    // flip-flop during the access phase.
    if (setup) begin
      unique case (1'b1)
        hit(paddr, `USFL_OFF_STATUS):   n.rdata = {24'h000000, q.st};
        hit(paddr, `USFL_OFF_DATA):     n.rdata = {24'h000000, q.rxdat};
        hit(paddr, `USFL_OFF_CTRL):     n.rdata = {27'h0000000, q.ctrl};
        hit(paddr, `USFL_OFF_IRQ_STAT): n.rdata = {27'h0000000, q.irq_st};
        hit(paddr, `USFL_OFF_IRQ_MASK):
          n.rdata = {27'h0000000, q.irq_mask};
        default:                        n.rdata = 32'h00000000;
      endcase
    end

    // Data register access after a status read: the clear half of the
    // read-then-access sequences. Only flags seen set are cleared.
    if (data_ac && q.snap_v) begin
      if (q.snap[`USFL_ST_OERR]) n.st[`USFL_ST_OERR] = 1'b0;
      if (q.snap[`USFL_ST_NF])   n.st[`USFL_ST_NF]   = 1'b0;
      if (q.snap[`USFL_ST_FERR]) n.st[`USFL_ST_FERR] = 1'b0;
      if (q.snap[`USFL_ST_PERR]) n.st[`USFL_ST_PERR] = 1'b0;
      if (!pwrite) begin
        // Only one word is buffered, so a read empties it when the status read saw data ready set.
        if (q.snap[`USFL_ST_RXIF]) n.st[`USFL_ST_RXIF] = 1'b0;
      end else begin
        if (q.snap[`USFL_ST_TIDLE]) n.st[`USFL_ST_TIDLE] = 1'b0;
        if (q.snap[`USFL_ST_TXIF])  n.st[`USFL_ST_TXIF]  = 1'b0;
      end
      n.snap_v = 1'b0;
    end

    // A status read opens a sequence; a later read restarts it.
    // The snapshot is the value the reader was shown, taken in setup, so
    // a flag that rises during the access phase is never cleared unseen.
    if (rd && hit(paddr, `USFL_OFF_STATUS)) begin
      n.snap   = q.rdata[7:0];
      n.snap_v = 1'b1;
    end

    // A data write fills the transmit register. A second write before
    // the shifter takes the first overwrites it; software must poll.
    if (wr && hit(paddr, `USFL_OFF_DATA)) begin
      n.txdat   = pwdata[7:0];
      n.tx_full = 1'b1;
    end

    // Control write; a rising transmit enable empties the buffer flag.
    if (wr && hit(paddr, `USFL_OFF_CTRL)) begin
      n.ctrl = pwdata[4:0];
      if (pwdata[`USFL_CT_TXEN] && !q.ctrl[`USFL_CT_TXEN]) begin
        n.st[`USFL_ST_TXIF] = 1'b1;
      end
    end

    // Mask write.
    if (wr && hit(paddr, `USFL_OFF_IRQ_MASK)) n.irq_mask = pwdata[4:0];

    // Writes to the status register fall through here untouched.
    if (wr && hit(paddr, `USFL_OFF_STATUS)) n.st = n.st;

    // A finished word from the engine.
    // Flags after this cycle's clears decide, so a word that arrives with
    // the clearing data read finds the register free.
    if (lk.rx_valid && q.ctrl[`USFL_CT_EN]) begin
      if (n.st[`USFL_ST_OERR]) begin
        // Word dropped while overrun stands.
        n.st = n.st;
      end else if (n.st[`USFL_ST_RXIF]) begin
        n.st[`USFL_ST_OERR] = 1'b1;
        ev[`USFL_IRQ_OVR] = 1'b1;
      end else begin
        n.rxdat = lk.rx_data;
        n.st[`USFL_ST_RXIF] = 1'b1;
        // Error flags land together with the data ready flag.
        n.st[`USFL_ST_NF]   = lk.rx_noise;
        n.st[`USFL_ST_FERR] = lk.rx_ferr;
        n.st[`USFL_ST_PERR] = lk.rx_perr;
        ev[`USFL_IRQ_RX]  = q.ctrl[`USFL_CT_RIE];
        ev[`USFL_IRQ_ERR] = lk.rx_noise | lk.rx_ferr | lk.rx_perr;
      end
    end

    // Hand the buffered word to the shifter when it is free. A break
    // request holds the word back until the break ends.
    if (q.tx_full && !lk.tx_busy && !q.load &&
        q.ctrl[`USFL_CT_TXEN] && !q.ctrl[`USFL_CT_BRK]) begin
      n.load    = 1'b1;
      n.tx_full = 1'b0;
      n.st[`USFL_ST_TXIF] = 1'b1;
      ev[`USFL_IRQ_TXE] = 1'b1;
    end

    // Idle only with the buffer empty, nothing shifting and nothing
    // queued; the load pulse covers the cycle before busy rises.
    if (q.st[`USFL_ST_TXIF] && !n.tx_full && !lk.tx_busy && !q.load &&
        !n.load && !q.ctrl[`USFL_CT_BRK]) begin
      if (!q.st[`USFL_ST_TIDLE]) ev[`USFL_IRQ_TIDLE] = 1'b1;
      n.st[`USFL_ST_TIDLE] = 1'b1;
    end else if (n.tx_full || lk.tx_busy || q.load || n.load ||
                 q.ctrl[`USFL_CT_BRK]) begin
      // Something queued or on the line: a stale idle would force the
      // pin high and swallow the frame.
      n.st[`USFL_ST_TIDLE] = 1'b0;
    end

    // Receiver idle follows the engine frame state.
    n.st[`USFL_ST_RIDLE] = ~lk.rx_busy;

    // A disabled port resets its flags and drops what it holds.
    if (!n.ctrl[`USFL_CT_EN]) begin
      n.ctrl[`USFL_CT_TXEN] = 1'b0;
      n.ctrl[`USFL_CT_BRK]  = 1'b0;
      n.st      = `USFL_STATUS_RST;
      n.tx_full = 1'b0;
      n.load    = 1'b0;
      n.snap_v  = 1'b0;
    end

    // Sticky events: write one to clear, a new event wins.
    if (wr && hit(paddr, `USFL_OFF_IRQ_STAT)) begin
      n.irq_st = q.irq_st & ~pwdata[4:0];
    end
    n.irq_st = n.irq_st | ev;

    // The pin is forced high whenever the transmitter reads idle.
    n.txp = n.st[`USFL_ST_TIDLE] ? 1'b1 : lk.tx_line;
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{ctrl: `USFL_CTRL_RST, st: `USFL_STATUS_RST,
             irq_st: `USFL_IRQ_RST, irq_mask: `USFL_IRQ_RST,
             txp: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  // Engine controls come straight from registers.
  assign lk.enable    = q.ctrl[`USFL_CT_EN];
  assign lk.parity_en = q.ctrl[`USFL_CT_PAR];
  assign lk.tx_break  = q.ctrl[`USFL_CT_BRK];
  assign lk.tx_load   = q.load;
  assign lk.tx_data   = q.txdat;

  // Bus answers: zero wait states, error on an unmapped address.
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped(paddr);
  assign prdata  = q.rdata;

  // Pin and interrupt outputs.
  assign tx_pin = q.txp;
  assign irq    = |(q.irq_st & q.irq_mask);

endmodule

// >>> verif/tb_top.sv
// Self-checking bench of the serial port status flag block.
// Assumes usfl_top on a 40 MHz clock and the partner on the serial pins.
`timescale 1ns/1ps
`include "usfl_regs.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_top;
  localparam logic [7:0] A_ST = `USFL_OFF_STATUS; // Status.
  localparam logic [7:0] A_DT = `USFL_OFF_DATA;   // Shared data.
  localparam logic [7:0] A_CT = `USFL_OFF_CTRL;   // Control.
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_pin, tx_pin, irq;
  logic [7:0]  paddr, got_byte, got_count, cnt0;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count = 0;
  int          samples_checked = 0;

  usfl_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .irq(irq));
  usfl_partner partner (.clk(clk), .rx_line(rx_pin), .tx_line(tx_pin),
    .got_byte(got_byte), .got_count(got_count));

  // Free-running 25 ns clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Case equality, so an unknown never counts as a match.
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Counts, verdict and end of run.
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer held until pready is sampled high; a bounded wait.
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      $display("BAD %0t no ready", $time);
      bad_count++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait, bounded, for the partner to capture one more frame.
  task automatic wait_frame();
    int n;
    for (n = 0; n < 5000 && got_count == cnt0; n++) @(posedge clk);
    if (got_count == cnt0) begin
      $display("BAD %0t no frame", $time);
      bad_count++;
      give_verdict();
    end
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Reset values, an ignored status write and an unmapped address.
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[7:0], `USFL_STATUS_RST);
    apb(A_CT, 1'b0, 32'h0);
    `CHK(rd, 32'h0);
    apb(A_ST, 1'b1, 32'hff);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[7:0], `USFL_STATUS_RST);
    apb(8'h20, 1'b0, 32'h0);
    `CHK(err, 1'b1);
    $display("test reset done");
    // A word queued with the sender off, then released by its enable.
    apb(A_CT, 1'b1, 32'h05);
    apb(A_ST, 1'b0, 32'h0);
    apb(A_DT, 1'b1, 32'h96);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[1:0], 2'b00);
    repeat (1000) @(posedge clk);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[1], 1'b0);
    cnt0 = got_count;
    apb(A_CT, 1'b1, 32'h07);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[0], 1'b1);
    wait_frame();
    `CHK(got_byte, 8'h96);
    repeat (400) @(posedge clk);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[1:0], 2'b11);
    $display("test transmit done");
    // Receive with the interrupt unmasked; idle flag checked mid-frame.
    apb(`USFL_OFF_IRQ_MASK, 1'b1, 32'h01);
    fork
      partner.send(8'ha5, 1'b1);
      begin
        repeat (1500) @(posedge clk);
        apb(A_ST, 1'b0, 32'h0);
        `CHK(rd[3], 1'b0);
      end
    join
    repeat (20) @(posedge clk);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[3:2], 2'b11);
    @(negedge clk);
    `CHK(irq, 1'b1);
    apb(A_DT, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'ha5);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[2], 1'b0);
    apb(`USFL_OFF_IRQ_STAT, 1'b1, 32'h01);
    @(negedge clk);
    `CHK(irq, 1'b0);
    $display("test receive done");
    // Data read after a status read that saw no word; then an overrun.
    partner.send(8'h5a, 1'b1);
    repeat (20) @(posedge clk);
    apb(A_DT, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'h5a);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[2], 1'b1);
    partner.send(8'h3c, 1'b1);
    repeat (20) @(posedge clk);
    apb(A_DT, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'h5a);
    partner.send(8'h77, 1'b1);
    repeat (20) @(posedge clk);
    apb(A_ST, 1'b0, 32'h0);
    `CHK({rd[4], rd[2]}, 2'b10);
    `CHK(rd[4], 1'b1);
    apb(A_DT, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'h5a);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[4], 1'b0);
    $display("test overrun done");
    // Framing fault arrives together with the data ready flag.
    partner.send(8'h81, 1'b0);
    repeat (20) @(posedge clk);
    apb(A_ST, 1'b0, 32'h0);
    `CHK({rd[5], rd[2]}, 2'b11);
    apb(A_DT, 1'b0, 32'h0);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[5], 1'b0);
    $display("test framing done");
    // Break holds a queued word; disabling restores the rest state.
    apb(A_CT, 1'b1, 32'h17);
    apb(A_ST, 1'b0, 32'h0);
    apb(A_DT, 1'b1, 32'h11);
    repeat (1000) @(posedge clk);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[1], 1'b0);
    `CHK(tx_pin, 1'b0);
    apb(A_CT, 1'b1, 32'h00);
    apb(A_ST, 1'b0, 32'h0);
    `CHK(rd[7:0], `USFL_STATUS_RST);
    `CHK(tx_pin, 1'b1);
    $display("test disable done");
    give_verdict();
  end
endmodule

bind usfl_top usfl_properties chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
  .tx_pin(tx_pin), .irq(irq));

// >>> verif/usfl_partner.sv
// Remote serial partner: sends frames on the receive pin and captures
// frames from the transmit pin. Assumes 8 data bits, one stop bit.
`timescale 1ns/1ps
`include "usfl_regs.svh"
module usfl_partner (
  input  wire logic       clk,
  output      logic       rx_line,
  input  wire logic       tx_line,
  output      logic [7:0] got_byte,
  output      logic [7:0] got_count
);
  localparam int BITC = `USFL_BIT_CYCLES; // Cycles per bit.

  // The line rests high before the first frame.
  initial begin
    rx_line = 1'b1;
    got_byte = 8'h00;
    got_count = 8'h00;
  end

  // Send one frame LSB first. A low stop level commands a framing fault,
  // the only wrong answer this model gives.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BITC) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask

  // Sample each transmitted bit in its middle; a break shows as zeros.
  always begin
    @(negedge tx_line);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clk);
      got_byte[i] = tx_line;
    end
    repeat (BITC) @(posedge clk);
    got_count++;
  end
endmodule

// >>> verif/usfl_properties.sv
// Concurrent checks of the serial port status flag block at its ports.
// Assumes APB on clk and the register layout of usfl_regs.svh.
`timescale 1ns/1ps
`include "usfl_regs.svh"
module usfl_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic        irq
);
  logic stat_rd; // Access phase of a status register read.
  logic any_rd;  // Access phase of any mapped read.
  logic off_q;   // Port disabled according to the last control write.

  assign stat_rd = psel && penable && !pwrite && paddr == `USFL_OFF_STATUS;
  assign any_rd  = psel && penable && !pwrite && !pslverr;

  // Follow the enable bit; reset leaves the port disabled.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_q <= 1'b1;
    end else if (psel && penable && pwrite && paddr == `USFL_OFF_CTRL) begin
      off_q <= !pwdata[`USFL_CT_EN];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  access_ready_a: assert property (psel && !penable ##1 psel && penable
    |-> pready) else $error("access phase without ready");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside an access phase");
  upper_zero_a: assert property (any_rd |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  err_ready_a: assert property (
    stat_rd && |prdata[7:5] |-> prdata[`USFL_ST_RXIF])
    else $error("error flag without data ready");
  idle_empty_a: assert property (
    stat_rd && prdata[`USFL_ST_TIDLE] |-> prdata[`USFL_ST_TXIF])
    else $error("transmit idle without buffer empty");
  idle_line_a: assert property (
    stat_rd && prdata[`USFL_ST_TIDLE] |-> tx_pin)
    else $error("transmit line low while idle");
  off_status_a: assert property (
    stat_rd && off_q && $past(off_q, 2) |-> prdata[7:0] == `USFL_STATUS_RST)
    else $error("disabled port status not at rest value");
  off_line_a: assert property (off_q && $past(off_q) |=> tx_pin)
    else $error("transmit line low while disabled");
endmodule
